/* dse_pkg.sv */
// Shared constants and types for the differential symbol encoder.
package dse_pkg;
  // Width of an incoming data word and of an offset table key.
  localparam int DSE_DATA_W = 8;
  // Depth of the offset table, one entry per possible key.
  localparam int DSE_TBL_DEPTH = 256;
  // Depth of the input data FIFO.
  localparam int DSE_FIFO_DEPTH = 16;
  // Pointer into the constellation state map.
  localparam int DSE_PTR_W = 8;
  // Counts of entries or states, 0 to 256.
  localparam int DSE_CNT_W = 9;
  // Largest number of bits that one symbol can take.
  localparam logic [3:0] DSE_MAX_BPS = 4'h8;
  // Number of constellation states of the default four-point map.
  localparam logic [8:0] DSE_DEF_STATES = 9'h004;
  // Constellation state taken at reset and at every restart.
  localparam logic [7:0] DSE_START_STATE = 8'h00;
  // The two coordinate levels of the default map, plus and minus one in Q2.14.
  localparam logic signed [15:0] DSE_LEVEL_POS = 16'sh4000;
  localparam logic signed [15:0] DSE_LEVEL_NEG = 16'shC000;
  // Bit s is set where default state s has a negative I or Q coordinate.
  localparam logic [3:0] DSE_DEF_I_NEG = 4'hA;
  localparam logic [3:0] DSE_DEF_Q_NEG = 4'hC;

  // Sequencer states of the encoder.
  typedef enum logic [1:0] {
    DSE_ST_FETCH = 2'b00,
    DSE_ST_LOOK = 2'b01,
    DSE_ST_MOVE = 2'b10,
    DSE_ST_HOLD = 2'b11
  } dse_state_t;

  // Kind of user-defined modulation that the symbols feed.
  typedef enum logic {
    DSE_MOD_IQ = 1'b0,
    DSE_MOD_FSK = 1'b1
  } dse_mod_t;

  // One write into the offset table.
  typedef struct packed {
    logic [7:0] key;
    logic signed [7:0] offset;
  } dse_tbl_wr_t;

  // One constellation state handed to the mapper.
  typedef struct packed {
    dse_mod_t kind;
    logic [7:0] state;
    logic signed [15:0] i_level;
    logic signed [15:0] q_level;
  } dse_sym_t;
endpackage

/* dse_fifo.sv */
`timescale 1ns/100ps
// Word FIFO with valid and ready on both sides; DEPTH must be a power of two.
module dse_fifo import dse_pkg::*; #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clock_in,
  input wire logic reset_n_in,
  input wire logic in_valid_in,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic in_ready_out,
  output logic out_valid_out,
  output logic [WIDTH-1:0] out_data_out,
  input wire logic out_ready_in
);
  localparam int AW = $clog2(DEPTH);
  // Storage words, not reset.
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  wire push = in_valid_in && in_ready_out;
  wire pop = out_valid_out && out_ready_in;
  wire [AW:0] next_count = count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

  assign out_valid_out = (count != '0);
  assign out_data_out = mem[rd_ptr];

  // Pointers, fill count and a registered ready that drops when full.
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      in_ready_out <= 1'b1;
    end else begin
      count <= next_count;
      in_ready_out <= (next_count != (AW+1)'(DEPTH));
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end

  // Word storage is written on every accepted push.
  always_ff @(posedge clock_in) begin
    if (push) begin
      mem[wr_ptr] <= in_data_in;
    end
  end
endmodule

/* dse_offset_mem.sv */
`timescale 1ns/100ps
// Offset table: one signed offset per key, read data from a register.
module dse_offset_mem import dse_pkg::*; #(
  parameter int DEPTH = 256,
  parameter int WIDTH = 8
) (
  input wire logic clock_in,
  input wire logic wr_en_in,
  input wire logic [$clog2(DEPTH)-1:0] wr_addr_in,
  input wire logic [WIDTH-1:0] wr_data_in,
  input wire logic rd_en_in,
  input wire logic [$clog2(DEPTH)-1:0] rd_addr_in,
  output logic [WIDTH-1:0] rd_data_out
);
  // Table storage, contents undefined until written.
  logic [WIDTH-1:0] mem [DEPTH];

  // Write port and registered read port.
  always_ff @(posedge clock_in) begin
    if (wr_en_in) begin
      mem[wr_addr_in] <= wr_data_in;
    end
    if (rd_en_in) begin
      rd_data_out <= mem[rd_addr_in];
    end
  end
endmodule

/* dse_encoder.sv */
`timescale 1ns/100ps
// Function
// - Symbol value carried by state change only.
// - Works for I/Q and FSK, table-driven.
// - Look up offset, move pointer by it.
// - Positive offset forward, negative offset backward.
// - Zero offset repeats the current state.
// - Output state depends on starting pointer.
// - Bits per symbol is ceil log2 entries.
// - Two entries: one bit, key LSB.
// - Four entries: two bits, keys 0-3.
// - Same symbol value, same relative move.
// - Pointer starts at first state, value 00.
// - Default map uses levels plus/minus one.
// - Encoding off maps symbols directly.
// - Table purged unless modulation saved.
module dse_encoder import dse_pkg::*; (
  input wire logic clock_in,
  input wire logic reset_n_in,
  input wire logic data_valid_in,
  input wire logic [DSE_DATA_W-1:0] data_in,
  output logic data_ready_out,
  input wire logic tbl_wr_valid_in,
  input wire dse_tbl_wr_t tbl_wr_in,
  input wire logic save_in,
  input wire logic discard_in,
  input wire logic diff_enable_in,
  input wire dse_mod_t mod_kind_in,
  input wire logic [DSE_CNT_W-1:0] num_states_in,
  input wire logic start_in,
  input wire logic sym_ready_in,
  output logic sym_valid_out,
  output dse_sym_t sym_out,
  output logic [DSE_CNT_W-1:0] entries_out,
  output logic [3:0] bits_per_symbol_out,
  output logic unsaved_out
);
  // Sequencer state.
  dse_state_t st;
  // Current position in the constellation state map.
  logic [DSE_PTR_W-1:0] ptr;
  // Left-aligned unused data bits and how many of them are valid.
  logic [15:0] sr;
  logic [4:0] have;
  // Symbol being encoded and its offset reduced modulo the state count.
  logic [7:0] sym;
  logic signed [9:0] offm;
  // Whether the offset path is used for the current symbol.
  logic diff_on;
  // FIFO read side.
  logic fifo_valid;
  logic [DSE_DATA_W-1:0] fifo_data;
  // Offset table read data.
  logic [7:0] rd_offset;

  // Ceiling of log2 of n, at least one, at most nine.
  function automatic logic [3:0] dse_ceil_log2(input logic [DSE_CNT_W-1:0] n);
    logic [3:0] r;
    r = 4'h1;
    // Each power of two that stays below n needs one more bit.
    for (int i = 1; i < 9; i++) begin
      if ((9'h001 << i) < n) begin
        r = 4'(i + 1);
      end
    end
    return r;
  endfunction

  // State count, never below one so the modulo stays defined.
  wire [DSE_CNT_W-1:0] n_eff = (num_states_in == '0) ? 9'h001 : num_states_in;
  wire signed [9:0] n_s = $signed({1'b0, n_eff});
  // Differential path needs a table of at least two entries.
  wire next_diff_on = diff_enable_in && (entries_out >= 9'h002);
  // Table width sets symbol width when encoding, state count otherwise.
  wire [3:0] next_bps = next_diff_on ? dse_ceil_log2(entries_out) : dse_ceil_log2(n_eff);
  // A symbol is ready once enough buffered bits are held.
  wire have_sym = ({1'b0, have} >= {2'b00, bits_per_symbol_out});
  wire fetch_sym = (st == DSE_ST_FETCH) && have_sym && !start_in;
  // Otherwise the buffer asks the FIFO for one more word.
  wire fetch_word = (st == DSE_ST_FETCH) && !have_sym && !start_in;
  // Take the top bits of the buffer; keys above the width read as zero.
  wire [7:0] next_sym = sr[15:8] >> (DSE_MAX_BPS - bits_per_symbol_out);
  // A new word lands just below the bits that are still held.
  wire [15:0] sr_fill = sr | ({fifo_data, 8'h00} >> have);
  // Pointer plus reduced offset, then folded back into the map.
  wire signed [9:0] sum = $signed({2'b00, ptr}) + offm;
  wire signed [9:0] wrapped = (sum < 10'sd0) ? sum + n_s : ((sum >= n_s) ? sum - n_s : sum);
  // Without encoding the symbol value picks the state itself.
  wire [8:0] direct = {1'b0, sym} % n_eff;
  // Encoding on moves the pointer; encoding off jumps to the symbol.
  wire [7:0] next_ptr = diff_on ? wrapped[7:0] : direct[7:0];
  // The low two state bits choose a point of the default map.
  wire [1:0] q_idx = next_ptr[1:0];
  // Coordinates of the default four-point map.
  wire signed [15:0] next_i = DSE_DEF_I_NEG[q_idx] ? DSE_LEVEL_NEG : DSE_LEVEL_POS;
  wire signed [15:0] next_q = DSE_DEF_Q_NEG[q_idx] ? DSE_LEVEL_NEG : DSE_LEVEL_POS;
  // Entry count grows to cover the highest key written.
  wire [DSE_CNT_W-1:0] key_top = {1'b0, tbl_wr_in.key} + 9'h001;

  // Input data FIFO, drained only when the bit buffer runs short.
  dse_fifo #(
    .WIDTH(DSE_DATA_W),
    .DEPTH(DSE_FIFO_DEPTH)
  ) u_fifo (
    .clock_in(clock_in),
    .reset_n_in(reset_n_in),
    .in_valid_in(data_valid_in),
    .in_data_in(data_in),
    .in_ready_out(data_ready_out),
    .out_valid_out(fifo_valid),
    .out_data_out(fifo_data),
    .out_ready_in(fetch_word)
  );

  // Offset table, written from the edit port and read once per symbol.
  dse_offset_mem #(
    .DEPTH(DSE_TBL_DEPTH),
    .WIDTH(8)
  ) u_table (
    .clock_in(clock_in),
    .wr_en_in(tbl_wr_valid_in),
    .wr_addr_in(tbl_wr_in.key),
    .wr_data_in(tbl_wr_in.offset),
    .rd_en_in(fetch_sym),
    .rd_addr_in(next_sym),
    .rd_data_out(rd_offset)
  );

  // Table bookkeeping: size and unsaved flag; a write wins over a purge.
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      // Reset forgets the table size and the edit flag.
      entries_out <= '0;
      unsaved_out <= 1'b0;
      bits_per_symbol_out <= 4'h1;
    end else begin
      // Symbol width follows the latest table size, state count and mode.
      bits_per_symbol_out <= next_bps;
      if (tbl_wr_valid_in) begin
        // A write marks the table edited; the highest key sets its size.
        unsaved_out <= 1'b1;
        if (key_top > entries_out) begin
          entries_out <= key_top;
        end
      end else if (discard_in && unsaved_out) begin
        // Leaving an edited table without saving throws it away.
        entries_out <= '0;
        unsaved_out <= 1'b0;
      end else if (save_in) begin
        // Saving keeps the table and clears the edit flag.
        unsaved_out <= 1'b0;
      end
    end
  end

  // Bit buffer: consumes a symbol or appends a word from the FIFO.
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      // Reset leaves the buffer empty.
      sr <= 16'h0000;
      have <= 5'h00;
      sym <= 8'h00;
    end else if (start_in) begin
      // A restart drops leftover bits; the FIFO keeps its words.
      sr <= 16'h0000;
      have <= 5'h00;
    end else if (fetch_sym) begin
      // One symbol leaves from the top of the buffer.
      sym <= next_sym;
      sr <= sr << bits_per_symbol_out;
      have <= have - {1'b0, bits_per_symbol_out};
    end else if (fetch_word && fifo_valid) begin
      // One FIFO word joins the bits still held.
      sr <= sr_fill;
      have <= have + 5'h08;
    end
  end

  // Sequencer: fetch, look up, move, hold for the mapper.
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      // Reset parks the sequencer at the first state with nothing shown.
      st <= DSE_ST_FETCH;
      ptr <= DSE_START_STATE;
      offm <= 10'sd0;
      diff_on <= 1'b0;
      sym_valid_out <= 1'b0;
      sym_out <= '0;
    end else if (start_in) begin
      // A restart withdraws any shown state and returns to the first one.
      st <= DSE_ST_FETCH;
      ptr <= DSE_START_STATE;
      sym_valid_out <= 1'b0;
    end else begin
      case (st)
        DSE_ST_FETCH: begin
          // The table read is launched in this cycle.
          if (fetch_sym) begin
            diff_on <= next_diff_on;
            st <= DSE_ST_LOOK;
          end
        end
        DSE_ST_LOOK: begin
          // Every occurrence of a key fetches the same stored offset.
          offm <= 10'($signed(rd_offset) % n_s);
          st <= DSE_ST_MOVE;
        end
        DSE_ST_MOVE: begin
          // Zero offset leaves the pointer where it was.
          ptr <= next_ptr;
          sym_out.kind <= mod_kind_in;
          sym_out.state <= next_ptr;
          sym_out.i_level <= next_i;
          sym_out.q_level <= next_q;
          sym_valid_out <= 1'b1;
          st <= DSE_ST_HOLD;
        end
        DSE_ST_HOLD: begin
          // State stands until the mapper takes it.
          if (sym_ready_in) begin
            sym_valid_out <= 1'b0;
            st <= DSE_ST_FETCH;
          end
        end
        default: begin
          // An unused code falls back to fetching.
          st <= DSE_ST_FETCH;
        end
      endcase
    end
  end

  // Checks on the encoder's own behaviour.
  default clocking dse_cb @(posedge clock_in); endclocking
  default disable iff (!reset_n_in);

  // One symbol passes through look-up, move and hold on consecutive cycles.
  sequence SEQ_ENCODE;
    (st == DSE_ST_LOOK) ##1 (st == DSE_ST_MOVE) ##1 (st == DSE_ST_HOLD && sym_valid_out);
  endsequence

  // A restart may cut a symbol short, so it ends this check.
  AST_PIPE: assert property (disable iff (!reset_n_in || start_in) fetch_sym |=> SEQ_ENCODE)
    else $error("symbol did not pass look-up and move in order");

  // A restart always lands on the first state with nothing shown.
  AST_START: assert property (start_in |=> (ptr == DSE_START_STATE) && !sym_valid_out)
    else $error("restart did not return pointer to first state");

  // A zero offset repeats the state that was already shown.
  AST_ZERO: assert property ((st == DSE_ST_MOVE) && diff_on && (offm == 10'sd0) && !start_in
      |=> (ptr == $past(ptr)) && (sym_out.state == $past(ptr)))
    else $error("zero offset moved the pointer");

  // Plus one steps to the next state where no wrap is due.
  AST_FWD: assert property ((st == DSE_ST_MOVE) && diff_on && (offm == 10'sd1) && !start_in
      && ({1'b0, ptr} != n_eff - 9'h001) |=> ptr == $past(ptr) + 8'h01)
    else $error("offset plus one did not step forward one state");

  // Minus one steps to the previous state where no wrap is due.
  AST_BACK: assert property ((st == DSE_ST_MOVE) && diff_on && (offm == -10'sd1) && !start_in
      && (ptr != 8'h00) |=> ptr == $past(ptr) - 8'h01)
    else $error("offset minus one did not step back one state");

  // Plus one from the last state continues at the first.
  AST_WRAP: assert property ((st == DSE_ST_MOVE) && diff_on && (offm == 10'sd1) && !start_in
      && ({1'b0, ptr} == n_eff - 9'h001) |=> ptr == 8'h00)
    else $error("pointer did not wrap past the last state");

  // With encoding off the state is the symbol folded into the map.
  AST_DIRECT: assert property ((st == DSE_ST_MOVE) && !diff_on && !start_in
      |=> {1'b0, sym_out.state} == {1'b0, sym} % n_eff)
    else $error("direct mapping did not follow the symbol");

  // Two entries give one bit per symbol and four entries give two.
  AST_BPS: assert property (((entries_out == 9'h002) || (entries_out == 9'h004)) && diff_enable_in
      |=> bits_per_symbol_out == (($past(entries_out) == 9'h004) ? 4'h2 : 4'h1))
    else $error("bits per symbol wrong for two or four entries");

  // With a steady table the width is the ceiling of log2 of its size.
  AST_CEIL: assert property (($past(next_diff_on) && $stable(entries_out))
      |-> ((9'h001 << bits_per_symbol_out) >= entries_out)
      && ((9'h001 << (bits_per_symbol_out - 4'h1)) < entries_out))
    else $error("bits per symbol is not the ceiling of log2 entries");

  // Leaving an edited table without saving empties it.
  AST_PURGE: assert property (discard_in && unsaved_out && !tbl_wr_valid_in
      |=> (entries_out == '0) && !unsaved_out)
    else $error("unsaved table was not purged");

  // Every coordinate shown is one of the two map levels.
  AST_LEVEL: assert property (sym_valid_out
      |-> (sym_out.i_level == DSE_LEVEL_POS || sym_out.i_level == DSE_LEVEL_NEG)
      && (sym_out.q_level == DSE_LEVEL_POS || sym_out.q_level == DSE_LEVEL_NEG))
    else $error("coordinate level is not plus or minus one");

  // A state waiting for the mapper does not change under it.
  AST_STAND: assert property (sym_valid_out && !sym_ready_in && !start_in |=> sym_valid_out && $stable(sym_out))
    else $error("output state changed before it was taken");

  // A state taken by the mapper is withdrawn on the next cycle.
  AST_TAKEN: assert property (sym_valid_out && sym_ready_in && !start_in |=> !sym_valid_out)
    else $error("taken symbol was not withdrawn");

  // Each shown state carries the modulation kind chosen at the move.
  AST_KIND: assert property ((st == DSE_ST_MOVE) && !start_in |=> sym_out.kind == $past(mod_kind_in))
    else $error("modulation kind was not carried with the state");
endmodule

/* dse_mapper_model.sv */
`timescale 1ns/100ps
// Model of the constellation mapper that takes states from the encoder.
module dse_mapper_model import dse_pkg::*; (
  input wire logic clock_in,
  input wire logic reset_n_in,
  input wire logic stall_in,
  input wire logic hold_in,
  input wire logic sym_valid_in,
  input wire dse_sym_t sym_in,
  output logic sym_ready_out
);
  // Symbols taken so far, in order; the bench reads and clears this.
  dse_sym_t got[$];
  // Free-running count that spaces out ready while stalling.
  logic [1:0] phase;

  // Ready is either always high, high one cycle in four, or held low.
  always @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      phase <= 2'h0;
      sym_ready_out <= 1'b0;
    end else begin
      // A symbol counts as taken only where valid and ready meet at this edge.
      if (sym_valid_in && sym_ready_out) begin
        got.push_back(sym_in);
      end
      phase <= phase + 2'h1;
      sym_ready_out <= !hold_in && (!stall_in || phase == 2'h3);
    end
  end
endmodule

/* differential_symbol_encoder_tb_top.sv */
`timescale 1ns/100ps
// Self-checking bench for the differential symbol encoder.
module differential_symbol_encoder_tb_top import dse_pkg::*;;
  logic clock_in;
  logic reset_n_in;
  logic data_valid_in;
  logic [7:0] data_in;
  logic data_ready_out;
  logic tbl_wr_valid_in;
  dse_tbl_wr_t tbl_wr_in;
  logic save_in;
  logic discard_in;
  logic diff_enable_in;
  dse_mod_t mod_kind_in;
  logic [8:0] num_states_in;
  logic start_in;
  logic sym_ready_in;
  logic sym_valid_out;
  dse_sym_t sym_out;
  logic [8:0] entries_out;
  logic [3:0] bits_per_symbol_out;
  logic unsaved_out;
  logic stall;
  logic hold;
  int fail_count;
  int checks_done;

  dse_encoder uut (.clock_in, .reset_n_in, .data_valid_in, .data_in, .data_ready_out, .tbl_wr_valid_in,
    .tbl_wr_in, .save_in, .discard_in, .diff_enable_in, .mod_kind_in, .num_states_in, .start_in,
    .sym_ready_in, .sym_valid_out, .sym_out, .entries_out, .bits_per_symbol_out, .unsaved_out);

  dse_mapper_model mapper (.clock_in, .reset_n_in, .stall_in(stall), .hold_in(hold),
    .sym_valid_in(sym_valid_out), .sym_in(sym_out), .sym_ready_out(sym_ready_in));

  // Clock of 40 ns period.
  initial begin
    clock_in = 1'b0;
    forever #20 clock_in = ~clock_in;
  end

  // Prints the verdict and ends the run.
  task automatic summarize();
    if (fail_count == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // Compares one value and reports a mismatch.
  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  // A wait that ran out counts as a mismatch and closes the run.
  task automatic give_up(input string what);
    fail_count++;
    $display("CHECK FAILED %s expected activity seen timeout", what);
    summarize();
  endtask

  // Expected symbol for a state of the default four-point map.
  function automatic dse_sym_t exp_sym(input logic [7:0] st);
    exp_sym.kind = mod_kind_in;
    exp_sym.state = st;
    exp_sym.i_level = DSE_DEF_I_NEG[st[1:0]] ? DSE_LEVEL_NEG : DSE_LEVEL_POS;
    exp_sym.q_level = DSE_DEF_Q_NEG[st[1:0]] ? DSE_LEVEL_NEG : DSE_LEVEL_POS;
  endfunction

  // Writes one offset table entry.
  task automatic tbl_write(input logic [7:0] key, input logic [7:0] off);
    @(negedge clock_in);
    tbl_wr_valid_in = 1'b1;
    tbl_wr_in = {key, off};
    @(negedge clock_in);
    tbl_wr_valid_in = 1'b0;
  endtask

  // One-cycle pulse: 0 save, 1 discard, 2 restart.
  task automatic pulse(input int sel);
    @(negedge clock_in);
    {start_in, discard_in, save_in} = 3'h1 << sel;
    @(negedge clock_in);
    {start_in, discard_in, save_in} = 3'h0;
  endtask

  // Offers a word and holds it until the FIFO takes it.
  task automatic send_word(input logic [7:0] w);
    int n;
    n = 0;
    @(negedge clock_in);
    data_valid_in = 1'b1;
    data_in = w;
    while (data_ready_out !== 1'b1) begin
      n++;
      if (n > 500) give_up("data_ready_out");
      @(negedge clock_in);
    end
    @(posedge clock_in);
  endtask

  // Withdraws the data offer.
  task automatic stop_data();
    @(negedge clock_in);
    data_valid_in = 1'b0;
  endtask

  // Waits for the mapper to hold the expected states, then compares them all.
  task automatic expect_states(input logic [7:0] exp_q[$], input string what);
    int n;
    n = 0;
    while (mapper.got.size() < exp_q.size()) begin
      n++;
      if (n > 4000) give_up(what);
      @(negedge clock_in);
    end
    repeat (8) @(negedge clock_in);
    check("symbol count", mapper.got.size(), exp_q.size());
    foreach (exp_q[i]) check(what, mapper.got[i], exp_sym(exp_q[i]));
    mapper.got.delete();
  endtask

  // Values held during reset.
  task automatic sc_reset();
    check("data_ready_out", data_ready_out, 1'b1);
    check("sym_valid_out", sym_valid_out, 1'b0);
    check("entries_out", entries_out, 9'h000);
    check("bits_per_symbol_out", bits_per_symbol_out, 4'h1);
    check("unsaved_out", unsaved_out, 1'b0);
  endtask

  // Symbol width follows the number of table entries.
  task automatic sc_table();
    tbl_write(8'h00, 8'h01);
    tbl_write(8'h01, 8'hFF);
    @(negedge clock_in);
    check("entries_out", entries_out, 9'h002);
    check("bits_per_symbol_out", bits_per_symbol_out, 4'h1);
    check("unsaved_out", unsaved_out, 1'b1);
    tbl_write(8'h02, 8'h02);
    @(negedge clock_in);
    check("bits_per_symbol_out", bits_per_symbol_out, 4'h2);
    tbl_write(8'h03, 8'h00);
    @(negedge clock_in);
    check("entries_out", entries_out, 9'h004);
    check("bits_per_symbol_out", bits_per_symbol_out, 4'h2);
  endtask

  // Stream 00 11 10 00 01 00 00 00, then 01 00 00 00, with a slow mapper, wrapping both ways.
  task automatic sc_diff();
    mod_kind_in = DSE_MOD_FSK;
    stall = 1'b1;
    pulse(2);
    send_word(8'h38);
    send_word(8'h40);
    stop_data();
    expect_states('{8'h01, 8'h01, 8'h03, 8'h00, 8'h03, 8'h00, 8'h01, 8'h02}, "diff state");
    send_word(8'h40);
    stop_data();
    expect_states('{8'h01, 8'h02, 8'h03, 8'h00}, "diff state");
  endtask

  // Encoding off maps symbols straight to states.
  task automatic sc_direct();
    mod_kind_in = DSE_MOD_IQ;
    diff_enable_in = 1'b0;
    repeat (2) @(negedge clock_in);
    check("bits_per_symbol_out", bits_per_symbol_out, 4'h2);
    pulse(2);
    send_word(8'h1B);
    stop_data();
    expect_states('{8'h00, 8'h01, 8'h02, 8'h03}, "direct state");
    diff_enable_in = 1'b1;
  endtask

  // Fill the FIFO with the mapper held off, then drain it while stalling.
  task automatic sc_fifo();
    int n;
    logic [7:0] q[$];
    n = 0;
    hold = 1'b1;
    pulse(2);
    repeat (2) @(negedge clock_in);
    while (n < 24) begin
      @(negedge clock_in);
      if (data_ready_out !== 1'b1) break;
      data_valid_in = 1'b1;
      data_in = 8'h00;
      @(posedge clock_in);
      n++;
    end
    data_valid_in = 1'b0;
    check("words held", n >= 16 && n <= 18, 1'b1);
    for (int i = 0; i < n * 4; i++) q.push_back(8'((i + 1) % 4));
    hold = 1'b0;
    expect_states(q, "drained state");
    check("data_ready_out", data_ready_out, 1'b1);
  endtask

  // Save keeps the table; an unsaved edit is purged on discard.
  task automatic sc_purge();
    pulse(0);
    check("unsaved_out", unsaved_out, 1'b0);
    pulse(1);
    check("entries_out", entries_out, 9'h004);
    tbl_write(8'h01, 8'hFF);
    @(negedge clock_in);
    check("unsaved_out", unsaved_out, 1'b1);
    check("entries_out", entries_out, 9'h004);
    pulse(1);
    check("entries_out", entries_out, 9'h000);
    check("unsaved_out", unsaved_out, 1'b0);
  endtask

  // Main sequence: reset for 16 cycles, then each scenario in turn.
  initial begin
    fail_count = 0;
    checks_done = 0;
    reset_n_in = 1'b0;
    data_valid_in = 1'b0;
    data_in = 8'h00;
    tbl_wr_valid_in = 1'b0;
    tbl_wr_in = '0;
    {start_in, discard_in, save_in} = 3'h0;
    diff_enable_in = 1'b1;
    mod_kind_in = DSE_MOD_IQ;
    num_states_in = 9'h004;
    stall = 1'b0;
    hold = 1'b0;
    repeat (16) @(posedge clock_in);
    sc_reset();
    @(negedge clock_in);
    reset_n_in = 1'b1;
    sc_table();
    sc_diff();
    sc_direct();
    sc_fifo();
    sc_purge();
    summarize();
  end
endmodule
